// >>> hw/rdio_defines.svh
`ifndef RDIO_DEFINES_SVH
`define RDIO_DEFINES_SVH

// ==========================================================
// apb register byte offsets
`define RDIO_OFF_CTRL      8'h00
`define RDIO_OFF_STATUS    8'h04
`define RDIO_OFF_PROG_NO   8'h08
`define RDIO_OFF_LINE_NO   8'h0c
`define RDIO_OFF_OVRD      8'h10
`define RDIO_OFF_FAULT_NO  8'h14
`define RDIO_OFF_NUM_IN    8'h18
`define RDIO_OFF_PORT_CFG  8'h1c
`define RDIO_OFF_ZONE_CFG  8'h20
`define RDIO_OFF_JOG_STAT  8'h24

// ==========================================================
// control register bit positions
`define RDIO_CTRL_TEACH    0
`define RDIO_CTRL_PSERVO   1
`define RDIO_CTRL_PJOG     2

// ==========================================================
// port and zone configuration and program number reset values
`define RDIO_PORT_CFG_RST  16'hf0f0
`define RDIO_ZONE_CFG_RST  8'h70
`define RDIO_VALUE_RST     16'h0000

// ==========================================================
// most user-zone outputs that may be set up
`define RDIO_ZONE_MAX      8

`endif

// >>> hw/rdio_pkg.sv
// ==========================================================
// shared types of the dedicated i/o block
package rdio_pkg;

   // which value the numeric output presents
   typedef enum logic [2:0] {
      RDIO_SEL_NONE  = 3'b000,
      RDIO_SEL_PROG  = 3'b001,
      RDIO_SEL_LINE  = 3'b010,
      RDIO_SEL_OVRD  = 3'b011,
      RDIO_SEL_FAULT = 3'b100
   } rdio_sel_t;

   // dedicated inputs as they enter the synchroniser
   typedef struct packed {
      logic [15:0] num_in;
      logic [4:0]  air;
      logic [4:0]  hand;
      logic [7:0]  jog_minus;
      logic [7:0]  jog_plus;
      logic [1:0]  jog_mode;
      logic        door_open;
      logic        estop;
      logic        servo_req;
      logic        clear_req;
      logic        jog_permit;
      logic        fault_no_req;
      logic        ovrd_req;
      logic        line_req;
      logic        prog_req;
   } rdio_in_t;

   // mask of bits first..last of a 16-bit port, empty when reversed
   function automatic logic [15:0] rdio_field_mask(input logic [3:0] first, input logic [3:0] last);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if ((4'(i) >= first) && (4'(i) <= last)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

endpackage

// >>> hw/rdio_in_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// two-stage synchroniser with a third stage for edge detection
module rdio_in_sync #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] raw_in,
   output logic      [W-1:0] level_out,
   output logic      [W-1:0] rise_out
);

   typedef struct packed {
      logic [W-1:0] meta;   // first stage, read only by second
      logic [W-1:0] stab;   // settled sample
      logic [W-1:0] prev;   // previous settled sample
   } rdio_sync_st_t;

   rdio_sync_st_t st_ff;
   rdio_sync_st_t nxt_st;

   // shift the stages
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = raw_in;
      nxt_st.stab = st_ff.meta;
      nxt_st.prev = st_ff.stab;
   end

   // register the stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out = st_ff.stab;
   assign rise_out  = st_ff.stab & ~st_ff.prev;

endmodule // rdio_in_sync

`default_nettype wire

// >>> hw/rdio_field_place.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// place a value on consecutive port bits first..last
module rdio_field_place #(
   parameter int MAX_BITS = 16
) (
   input  wire logic [15:0] value_in,
   input  wire logic [3:0]  first,
   input  wire logic [3:0]  last,
   output logic      [15:0] placed
);

   logic [3:0] eff_last;   // last bit after width limit

   // clip the field to MAX_BITS and shift the value into it
   always_comb begin
      eff_last = last;
      if ({1'b0, last} > ({1'b0, first} + 5'(MAX_BITS - 1))) begin
         eff_last = 4'(first + 4'(MAX_BITS - 1));
      end
      placed = (value_in << first) & rdio_pkg::rdio_field_mask(first, eff_last);
   end

endmodule // rdio_field_place

`default_nettype wire

// >>> hw/rdio_top.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rdio_defines.svh"

module rdio_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // dedicated inputs from the sequencer
   input  wire logic [15:0] numeric_value_port,
   input  wire logic        program_number_request,
   input  wire logic        line_number_request,
   input  wire logic        override_value_request,
   input  wire logic        fault_number_request,
   input  wire logic        external_jog_permit,
   input  wire logic [1:0]  jog_mode_select,
   input  wire logic [7:0]  jog_plus_in,
   input  wire logic [7:0]  jog_minus_in,
   input  wire logic [4:0]  hand_fault_mech,
   input  wire logic [4:0]  air_pressure_fault_mech,
   input  wire logic        fault_clear_request,
   input  wire logic        servo_power_request,
   input  wire logic        estop_in,
   input  wire logic        door_open_in,
   // dedicated outputs to the sequencer
   output logic      [15:0] numeric_value_out,
   output logic             prog_no_ind,
   output logic             line_no_ind,
   output logic             ovrd_ind,
   output logic             fault_no_ind,
   output logic             jog_valid,
   output logic      [1:0]  jog_mode_echo,
   output logic      [7:0]  jog_plus_req,
   output logic      [7:0]  jog_minus_req,
   output logic      [4:0]  hand_fault_out,
   output logic      [4:0]  air_fault_out,
   output logic      [15:0] user_zone_indicator,
   output logic             estop_out,
   output logic             servo_on,
   output logic             fault_active,
   output logic             robot_halt
);

   // ==========================================================
   // state of the block
   typedef struct packed {
      // software registers
      logic                teach;        // teaching operation selected
      logic                pend_jog;     // pendant motion request
      logic [15:0]         prog_no;      // current program number
      logic [15:0]         line_no;      // executing line number
      logic [15:0]         ovrd;         // present override value
      logic [15:0]         fault_no;     // active fault number
      logic [15:0]         port_cfg;     // numeric port bit ranges
      logic [15:0]         zone_cfg;     // zone range and zone flags
      // block state
      rdio_pkg::rdio_sel_t sel;          // value on numeric output
      rdio_pkg::rdio_sel_t shown;        // selection whose value is on the pins
      logic                jog_ok;       // external jog permitted
      logic                servo;        // servo powered
      logic                fault;        // error state
      logic [15:0]         num_out;      // numeric output pins
      logic [15:0]         zone_out;     // user-zone output pins
      logic [1:0]          jmode;        // echoed jog mode
      logic [7:0]          jplus;        // plus jog requests
      logic [7:0]          jminus;       // minus jog requests
      logic [4:0]          hand;         // hand fault outputs
      logic [4:0]          air;          // air fault outputs
      logic                estop_o;      // stop output
      logic                halt;         // robot halted
      // bus answer
      logic [31:0]         rdata;        // read data for access phase
      logic                err;          // unmapped address seen
   } rdio_st_t;

   rdio_st_t          st_ff;             // registered state
   rdio_st_t          nxt_st;            // next state

   rdio_pkg::rdio_in_t raw_vec;          // dedicated inputs packed
   rdio_pkg::rdio_in_t lvl;              // synchronised levels
   rdio_pkg::rdio_in_t rise;             // synchronised rising edges

   logic [15:0]       num_src;           // value chosen for numeric output
   logic [15:0]       num_placed;        // value on the output bit range
   logic [15:0]       zone_placed;       // zone flags on their bit range
   logic [15:0]       num_in_val;        // value read from input bits
   logic              wr_acc;            // write taken this edge
   logic              rd_setup;          // setup phase of any access
   logic              door_stop;         // door open forces stop
   logic              pend_servo;        // pendant servo-on strobe

   // ==========================================================
   // input synchronisation
   assign raw_vec = '{num_in:       numeric_value_port,
                      air:          air_pressure_fault_mech,
                      hand:         hand_fault_mech,
                      jog_minus:    jog_minus_in,
                      jog_plus:     jog_plus_in,
                      jog_mode:     jog_mode_select,
                      door_open:    door_open_in,
                      estop:        estop_in,
                      servo_req:    servo_power_request,
                      clear_req:    fault_clear_request,
                      jog_permit:   external_jog_permit,
                      fault_no_req: fault_number_request,
                      ovrd_req:     override_value_request,
                      line_req:     line_number_request,
                      prog_req:     program_number_request};

   // every dedicated input passes two flops; edges come from a third
   rdio_in_sync #(
      .W         ($bits(rdio_pkg::rdio_in_t))
   ) u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .raw_in    (raw_vec),
      .level_out (lvl),
      .rise_out  (rise)
   );

   // ==========================================================
   // numeric value port
   // input value: bits in_first..in_last shifted down to bit 0
   assign num_in_val = (lvl.num_in & rdio_pkg::rdio_field_mask(st_ff.port_cfg[3:0], st_ff.port_cfg[7:4]))
                       >> st_ff.port_cfg[3:0];

   // pick the value that the active request asked for
   always_comb begin
      case (st_ff.sel)
         rdio_pkg::RDIO_SEL_PROG:  num_src = st_ff.prog_no;
         rdio_pkg::RDIO_SEL_LINE:  num_src = st_ff.line_no;
         rdio_pkg::RDIO_SEL_OVRD:  num_src = st_ff.ovrd;
         rdio_pkg::RDIO_SEL_FAULT: num_src = st_ff.fault_no;
         default:                  num_src = 16'h0000;
      endcase
   end

   // output value lands on bits out_first..out_last
   rdio_field_place #(
      .MAX_BITS (16)
   ) u_num_place (
      .value_in (num_src),
      .first    (st_ff.port_cfg[11:8]),
      .last     (st_ff.port_cfg[15:12]),
      .placed   (num_placed)
   );

   // zone flags land on at most eight consecutive bits
   rdio_field_place #(
      .MAX_BITS (`RDIO_ZONE_MAX)
   ) u_zone_place (
      .value_in ({8'h00, st_ff.zone_cfg[15:8]}),
      .first    (st_ff.zone_cfg[3:0]),
      .last     (st_ff.zone_cfg[7:4]),
      .placed   (zone_placed)
   );

   // ==========================================================
   // bus decode
   assign rd_setup   = psel & ~penable;
   assign wr_acc     = psel & penable & pwrite;
   assign pend_servo = wr_acc && (paddr == `RDIO_OFF_CTRL) && pwdata[`RDIO_CTRL_PSERVO];
   // an open door stops the robot unless teaching
   assign door_stop  = lvl.door_open & ~st_ff.teach;

   // ==========================================================
   // next state
   always_comb begin
      nxt_st = st_ff;

      // register writes at the access edge
      if (wr_acc) begin
         case (paddr)
            `RDIO_OFF_CTRL: begin
               nxt_st.teach    = pwdata[`RDIO_CTRL_TEACH];
               nxt_st.pend_jog = pwdata[`RDIO_CTRL_PJOG];
            end
            `RDIO_OFF_PROG_NO:  nxt_st.prog_no  = pwdata[15:0];
            `RDIO_OFF_LINE_NO:  nxt_st.line_no  = pwdata[15:0];
            `RDIO_OFF_OVRD:     nxt_st.ovrd     = pwdata[15:0];
            `RDIO_OFF_FAULT_NO: nxt_st.fault_no = pwdata[15:0];
            `RDIO_OFF_PORT_CFG: nxt_st.port_cfg = pwdata[15:0];
            `RDIO_OFF_ZONE_CFG: nxt_st.zone_cfg = pwdata[15:0];
            default: begin
               nxt_st.err = st_ff.err;
            end
         endcase
      end

      // read data and error are prepared in the setup cycle
      if (rd_setup) begin
         nxt_st.err = 1'b0;
         case (paddr)
            `RDIO_OFF_CTRL:     nxt_st.rdata = {29'h0, st_ff.pend_jog, 1'b0, st_ff.teach};
            `RDIO_OFF_STATUS:   nxt_st.rdata = {24'h0, lvl.door_open, lvl.estop, st_ff.halt,
                                                st_ff.estop_o, st_ff.jog_ok, st_ff.fault,
                                                st_ff.servo, st_ff.sel != rdio_pkg::RDIO_SEL_NONE};
            `RDIO_OFF_PROG_NO:  nxt_st.rdata = {16'h0, st_ff.prog_no};
            `RDIO_OFF_LINE_NO:  nxt_st.rdata = {16'h0, st_ff.line_no};
            `RDIO_OFF_OVRD:     nxt_st.rdata = {16'h0, st_ff.ovrd};
            `RDIO_OFF_FAULT_NO: nxt_st.rdata = {16'h0, st_ff.fault_no};
            `RDIO_OFF_NUM_IN:   nxt_st.rdata = {16'h0, num_in_val};
            `RDIO_OFF_PORT_CFG: nxt_st.rdata = {16'h0, st_ff.port_cfg};
            `RDIO_OFF_ZONE_CFG: nxt_st.rdata = {16'h0, st_ff.zone_cfg};
            `RDIO_OFF_JOG_STAT: nxt_st.rdata = {4'h0, st_ff.air, st_ff.hand, st_ff.jmode,
                                                st_ff.jminus, st_ff.jplus};
            default: begin
               nxt_st.rdata = 32'h0000_0000;
               nxt_st.err   = 1'b1;
            end
         endcase
      end

      // numeric output request edges, first request wins a tie
      if (rise.prog_req) begin
         nxt_st.sel = rdio_pkg::RDIO_SEL_PROG;
      end else if (rise.line_req) begin
         nxt_st.sel = rdio_pkg::RDIO_SEL_LINE;
      end else if (rise.ovrd_req) begin
         nxt_st.sel = rdio_pkg::RDIO_SEL_OVRD;
      end else if (rise.fault_no_req) begin
         nxt_st.sel = rdio_pkg::RDIO_SEL_FAULT;
      end
      nxt_st.num_out = num_placed;
      // indicator moves with its value, so it never flags a stale number
      nxt_st.shown   = st_ff.sel;

      // jog permission holds after the input falls, dropped by estop
      if (rise.jog_permit) begin
         nxt_st.jog_ok = 1'b1;
      end else if (lvl.estop) begin
         nxt_st.jog_ok = 1'b0;
      end
      nxt_st.jmode = lvl.jog_mode;

      // jog requests pass only while on and permitted; both sides cancel
      nxt_st.jplus  = (st_ff.jog_ok && st_ff.servo) ? (lvl.jog_plus & ~lvl.jog_minus) : 8'h00;
      nxt_st.jminus = (st_ff.jog_ok && st_ff.servo) ? (lvl.jog_minus & ~lvl.jog_plus) : 8'h00;

      // mechanism faults follow their inputs
      nxt_st.hand = lvl.hand;
      nxt_st.air  = lvl.air;

      // user-zone outputs
      nxt_st.zone_out = zone_placed;

      // fault state: clear edge clears, a new cause wins over the clear
      if (rise.clear_req) begin
         nxt_st.fault = 1'b0;
      end
      if (lvl.estop || door_stop) begin
         nxt_st.fault = 1'b1;
      end

      // servo: switched on by request edges, forced off by stops
      if ((rise.servo_req || pend_servo) && !st_ff.fault) begin
         nxt_st.servo = 1'b1;
      end
      // opening the door drops the servo in either mode; teaching may then re-enable it from the pendant
      if (lvl.estop || door_stop || rise.door_open ||
          (lvl.door_open && !pend_servo && !st_ff.servo && rise.servo_req)) begin
         nxt_st.servo = 1'b0;
      end

      // stop output and halt state
      nxt_st.estop_o = lvl.estop | lvl.door_open;
      nxt_st.halt    = lvl.estop | door_stop | ~st_ff.servo;
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff          <= '0;
         st_ff.sel      <= rdio_pkg::RDIO_SEL_NONE;
         st_ff.port_cfg <= `RDIO_PORT_CFG_RST;
         st_ff.zone_cfg <= {8'h00, `RDIO_ZONE_CFG_RST};
         st_ff.prog_no  <= `RDIO_VALUE_RST;
         st_ff.halt     <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign pready              = 1'b1;            // zero wait states
   assign prdata              = st_ff.rdata;
   assign pslverr             = st_ff.err & psel & penable;
   assign numeric_value_out   = st_ff.num_out;
   assign prog_no_ind         = st_ff.shown == rdio_pkg::RDIO_SEL_PROG;
   assign line_no_ind         = st_ff.shown == rdio_pkg::RDIO_SEL_LINE;
   assign ovrd_ind            = st_ff.shown == rdio_pkg::RDIO_SEL_OVRD;
   assign fault_no_ind        = st_ff.shown == rdio_pkg::RDIO_SEL_FAULT;
   assign jog_valid           = st_ff.jog_ok;
   assign jog_mode_echo       = st_ff.jmode;
   assign jog_plus_req        = st_ff.jplus;
   assign jog_minus_req       = st_ff.jminus;
   assign hand_fault_out      = st_ff.hand;
   assign air_fault_out       = st_ff.air;
   assign user_zone_indicator = st_ff.zone_out;
   assign estop_out           = st_ff.estop_o;
   assign servo_on            = st_ff.servo;
   assign fault_active        = st_ff.fault;
   assign robot_halt          = st_ff.halt;

endmodule // rdio_top

`default_nettype wire

// >>> tb/rdio_checker.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// timing and safety relations seen at the top-level pins
module rdio_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pslverr,
   input wire logic       program_number_request,
   input wire logic       line_number_request,
   input wire logic       override_value_request,
   input wire logic       fault_number_request,
   input wire logic [4:0] hand_fault_mech,
   input wire logic [4:0] air_pressure_fault_mech,
   input wire logic       estop_in,
   input wire logic       door_open_in,
   input wire logic       prog_no_ind,
   input wire logic       line_no_ind,
   input wire logic       ovrd_ind,
   input wire logic       fault_no_ind,
   input wire logic [7:0] jog_plus_req,
   input wire logic [7:0] jog_minus_req,
   input wire logic [4:0] hand_fault_out,
   input wire logic [4:0] air_fault_out,
   input wire logic       estop_out,
   input wire logic       servo_on,
   input wire logic       fault_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // cycles since reset release, so $past never looks into reset
   logic [2:0] up_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_ff <= 3'h0;
      end else if (up_ff != 3'h4) begin
         up_ff <= up_ff + 3'h1;
      end
   end

   stop_echo_a: assert property (up_ff == 3'h4 |-> estop_out == $past(estop_in || door_open_in, 3))
      else $error("stop output does not follow stop or door input");
   hand_echo_a: assert property (up_ff == 3'h4 |-> hand_fault_out == $past(hand_fault_mech, 3))
      else $error("hand fault output does not follow input");
   air_echo_a: assert property (up_ff == 3'h4 |-> air_fault_out == $past(air_pressure_fault_mech, 3))
      else $error("air fault output does not follow input");
   ind_single_a: assert property ($onehot0({prog_no_ind, line_no_ind, ovrd_ind, fault_no_ind}))
      else $error("more than one value indicator high");
   jog_excl_a: assert property ((jog_plus_req & jog_minus_req) == 8'h00)
      else $error("plus and minus jog requested on one axis");
   prog_rise_a: assert property (up_ff == 3'h4 && $rose(program_number_request) && !line_number_request
      && !override_value_request && !fault_number_request |-> ##[2:5] prog_no_ind)
      else $error("program request not answered");
   estop_stop_a: assert property (estop_in [*4] |-> ##1 (!servo_on && fault_active))
      else $error("servo still on during emergency stop");
   slverr_phase_a: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
endmodule // rdio_checker

bind rdio_top rdio_checker chk_i (.pclk, .presetn, .psel, .penable, .pslverr, .program_number_request,
   .line_number_request, .override_value_request, .fault_number_request, .hand_fault_mech,
   .air_pressure_fault_mech, .estop_in, .door_open_in, .prog_no_ind, .line_no_ind, .ovrd_ind, .fault_no_ind,
   .jog_plus_req, .jog_minus_req, .hand_fault_out, .air_fault_out, .estop_out, .servo_on, .fault_active);

`default_nettype wire

// >>> tb/rdio_plc_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// sequencer side: edge requests as held pulses, numeric bits as levels
module rdio_plc_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        go,
   input  wire logic [6:0]  pick,
   input  wire logic [15:0] val_in,
   output logic      [6:0]  req,
   output logic      [15:0] num_out
);
   logic [1:0] cnt_ff; // cycles left in the current pulse

   // raise picked requests for three cycles, then drop them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req     <= 7'h00;
         cnt_ff  <= 2'h0;
         num_out <= 16'h0000;
      end else begin
         num_out <= val_in;
         if (go && cnt_ff == 2'h0) begin
            req    <= pick;
            cnt_ff <= 2'h3;
         end else if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
            if (cnt_ff == 2'h1) begin
               req <= 7'h00;
            end
         end
      end
   end
endmodule // rdio_plc_model

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rdio_defines.svh"

// ==========================================================
// directed bench over apb and the dedicated pins
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, go, pslverr, pready, err;
   logic        estop, door, ind_p, ind_l, ind_o, ind_f, jvalid, eout, son, fact, halt;
   logic [7:0]  paddr, jp, jm, jpr, jmr;
   logic [31:0] pwdata, prdata, rdat;
   logic [6:0]  pick, req;
   logic [15:0] val, nport, nout, zone, v;
   logic [4:0]  hand, air, hout, aout;
   logic [1:0]  mode, mecho;
   int          num_errors, tests_run, cyc;

   rdio_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .numeric_value_port(nport), .program_number_request(req[0]), .line_number_request(req[1]),
      .override_value_request(req[2]), .fault_number_request(req[3]), .external_jog_permit(req[4]),
      .jog_mode_select(mode), .jog_plus_in(jp), .jog_minus_in(jm), .hand_fault_mech(hand),
      .air_pressure_fault_mech(air), .fault_clear_request(req[5]), .servo_power_request(req[6]),
      .estop_in(estop), .door_open_in(door), .numeric_value_out(nout), .prog_no_ind(ind_p),
      .line_no_ind(ind_l), .ovrd_ind(ind_o), .fault_no_ind(ind_f), .jog_valid(jvalid), .jog_mode_echo(mecho),
      .jog_plus_req(jpr), .jog_minus_req(jmr), .hand_fault_out(hout), .air_fault_out(aout),
      .user_zone_indicator(zone), .estop_out(eout), .servo_on(son), .fault_active(fact), .robot_halt(halt));
   rdio_plc_model plc (.pclk, .presetn, .go, .pick, .val_in(val), .req, .num_out(nport));

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // compare and count
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one apb transfer, read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // pulse the picked edge requests through the sequencer model
   task automatic pulse(input logic [6:0] m);
      @(posedge pclk);
      go <= 1'b1; pick <= m;
      @(posedge pclk);
      go <= 1'b0;
      wt(10);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      {psel, penable, pwrite, go, estop, door, paddr, jp, jm, pwdata, pick, val, hand, air, mode} = '0;
      num_errors = 0; tests_run = 0; cyc = 0; presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `RDIO_OFF_PORT_CFG, 32'h0); chk("port_cfg", rdat, 32'h0000f0f0);
      apb(1'b0, `RDIO_OFF_ZONE_CFG, 32'h0); chk("zone_cfg", rdat, 32'h00000070);
      apb(1'b0, 8'h28, 32'h0); chk("unmapped", {err, rdat[30:0]}, 32'h80000000);
      $display("test registers done");
      // in bits 0..7, out bits 4..11; each request shows its own value
      apb(1'b1, `RDIO_OFF_PORT_CFG, 32'h0000b470);
      val <= 16'h3c5a;
      for (int i = 0; i < 4; i++) begin
         v = 16'h1234 * 16'(i + 1);
         apb(1'b1, `RDIO_OFF_PROG_NO + 8'(4 * i), {16'h0, v});
         pulse(7'(1 << i));
         chk("num_out", {16'h0, nout}, {16'h0, (v << 4) & 16'h0ff0});
         chk("ind", {28'h0, ind_f, ind_o, ind_l, ind_p}, 32'(1 << i));
      end
      apb(1'b0, `RDIO_OFF_NUM_IN, 32'h0); chk("num_in", rdat, 32'h0000005a);
      $display("test numeric done");
      hand <= 5'h15; air <= 5'h0a; mode <= 2'h2;
      wt(6);
      chk("faults", {20'h0, mecho, aout, hout}, 32'h00000955);
      apb(1'b0, `RDIO_OFF_JOG_STAT, 32'h0); chk("jog_stat", rdat, 32'h05560000);
      hand <= 5'h00; air <= 5'h00;
      wt(6);
      chk("faults_off", {22'h0, aout, hout}, 32'h0);
      pulse(7'h40); chk("servo", {31'h0, son}, 32'h1);
      pulse(7'h10);
      jp <= 8'h81; jm <= 8'h01;
      wt(6);
      chk("jog", {15'h0, jvalid, jmr, jpr}, 32'h00010080);
      jp <= 8'h00; jm <= 8'h00;
      $display("test jog done");
      door <= 1'b1;
      wt(6);
      chk("door_auto", {28'h0, eout, son, fact, halt}, 32'hb);
      pulse(7'h20); chk("clear_blocked", {31'h0, fact}, 32'h1);
      door <= 1'b0;
      wt(6);
      pulse(7'h20); chk("clear", {31'h0, fact}, 32'h0);
      pulse(7'h40); chk("servo_again", {31'h0, son}, 32'h1);
      apb(1'b1, `RDIO_OFF_CTRL, 32'h1);
      door <= 1'b1;
      wt(6);
      chk("door_teach", {29'h0, eout, son, fact}, 32'h4);
      apb(1'b1, `RDIO_OFF_CTRL, 32'h3);
      wt(3);
      chk("pendant_servo", {28'h0, eout, son, fact, halt}, 32'hc);
      door <= 1'b0; estop <= 1'b1;
      wt(6);
      chk("estop", {28'h0, eout, son, fact, jvalid}, 32'ha);
      estop <= 1'b0;
      wt(6);
      pulse(7'h20); chk("estop_clear", {31'h0, fact}, 32'h0);
      $display("test safety done");
      apb(1'b1, `RDIO_OFF_ZONE_CFG, 32'h00000b52);
      wt(3);
      chk("zone", {16'h0, zone}, 32'h0000002c);
      apb(1'b1, `RDIO_OFF_ZONE_CFG, 32'h0000fff0);
      wt(3);
      chk("zone_clip", {16'h0, zone}, 32'h000000ff);
      $display("test zone done");
      stop_test();
   end
endmodule // testbench

`default_nettype wire
